// *** core/ext_cap_pkg.sv ***
// Constants for the extended capability register bank: offsets, field
// positions, fixed field values and reset values.
// Assumes a 12-bit byte address space with one 32-bit word per register.
`default_nettype none

package ext_cap_pkg;

   // Bus shape
   localparam int ADDR_W = 12;
   localparam int DATA_W = 32;
   localparam int HDR_WORDS = 4;

   // Register byte offsets
   localparam logic [11:0] OFF_ERR_HDR0 = 12'h11c;
   localparam logic [11:0] OFF_ERR_HDR1 = 12'h120;
   localparam logic [11:0] OFF_ERR_HDR2 = 12'h124;
   localparam logic [11:0] OFF_ERR_HDR3 = 12'h128;
   localparam logic [11:0] OFF_SERIAL_CAP = 12'h180;
   localparam logic [11:0] OFF_UID_LOW = 12'h184;
   localparam logic [11:0] OFF_UID_HIGH = 12'h188;
   localparam logic [11:0] OFF_VCHAN_CAP = 12'h200;
   localparam logic [11:0] OFF_PORT_VCHAN_CAP1 = 12'h204;
   localparam logic [11:0] OFF_LOCK_STATUS = 12'h300;

   // Capability header field positions and values
   localparam int CAP_ID_LSB = 0;
   localparam int CAP_VER_LSB = 16;
   localparam int NEXT_PTR_LSB = 20;
   localparam logic [15:0] CAP_ID_SERIAL = 16'h0003;
   localparam logic [15:0] CAP_ID_VCHAN = 16'h0002;
   localparam logic [3:0] CAP_VERSION = 4'h1;
   localparam logic [11:0] NEXT_PTR_RESET = 12'h000;

   // Port VC capability one fields
   localparam int EXTRA_VC_LSB = 0;
   localparam int LP_EXTRA_VC_LSB = 4;
   localparam int ARB_REF_CLK_LSB = 8;
   localparam int ENTRY_SIZE_LSB = 10;
   localparam logic [2:0] EXTRA_VC_COUNT = 3'h0;
   localparam logic [2:0] LP_EXTRA_VC_COUNT = 3'h0;
   localparam logic [1:0] ARB_REF_CLK = 2'h0;
   localparam logic [1:0] ENTRY_SIZE_1BIT = 2'h0;
   localparam logic [1:0] ENTRY_SIZE_2BIT = 2'h1;
   localparam logic [1:0] ENTRY_SIZE_4BIT = 2'h2;
   localparam logic [1:0] ENTRY_SIZE_8BIT = 2'h3;

   // Lock and status register fields
   localparam int UNLOCK_BIT = 0;
   localparam int LOG_FULL_BIT = 1;
   localparam logic UNLOCK_RESET = 1'b0;

   // Reset values
   localparam logic [31:0] UID_RESET = 32'h0000_0000;
   localparam logic [31:0] HDR_RESET = 32'h0000_0000;

endpackage

`default_nettype wire

// *** core/hdr_log_if.sv ***
// Carrier between the register bank and the error header store.
// Assumes both ends run on the same clock.
`timescale 1ns/1ns
`default_nettype none

interface hdr_log_if;
   logic capture;
   logic rearm;
   logic [127:0] header;
   logic [ext_cap_pkg::HDR_WORDS-1:0][31:0] words;
   logic full;

   modport store (input capture, input rearm, input header, output words, output full);
   modport user (output capture, output rearm, output header, input words, input full);
endinterface

`default_nettype wire

// *** core/error_header_store.sv ***
// Sticky store for the four header words of the first logged error.
// Assumes only the fundamental reset clears it; hot resets never reach it.
`timescale 1ns/1ns
`default_nettype none

module error_header_store (
   // Clock and fundamental reset
   input wire logic i_clk,
   input wire logic i_srst,
   // Carrier to the register bank
   hdr_log_if.store log
);

   typedef struct packed {
      logic full;
      logic [ext_cap_pkg::HDR_WORDS-1:0][31:0] words;
   } store_state_t;

   store_state_t state_reg;
   store_state_t state_next;

   // Capture only while armed; a rearm in the same cycle as an error
   // lets that error in, so no event is lost to the clear
   always_comb begin
      state_next = state_reg;
      if (log.capture && (!state_reg.full || log.rearm)) begin
         for (int i = 0; i < ext_cap_pkg::HDR_WORDS; i++) begin
            state_next.words[i] = log.header[i*32 +: 32]; // [R1]
         end
         state_next.full = 1'b1;
      end else if (log.rearm) begin
         state_next.full = 1'b0;
      end
   end

   // Sticky: only the fundamental reset clears the words; a rearm clears just the full flag
   always_ff @(posedge i_clk) begin
      if (i_srst) begin
         state_reg.full <= 1'b0;
         for (int i = 0; i < ext_cap_pkg::HDR_WORDS; i++) begin
            state_reg.words[i] <= ext_cap_pkg::HDR_RESET; // [R12]
         end
      end else begin
         state_reg <= state_next;
      end
   end

   assign log.words = state_reg.words;
   assign log.full = state_reg.full;

endmodule

`default_nettype wire

// *** core/pcie_ext_cap_error_log_serial_vc.sv ***
// Extended configuration registers of one switch port: error header log,
// device serial number capability and virtual channel capability header.
// Assumes a same-clock register master and same-clock error logic.
`timescale 1ns/1ns
`default_nettype none

// Function
// R1: First uncorrectable error header, four words, kept read-only and sticky, reset zero.
// R2: Serial number header reads identifier 0x3 in bits 15 to 0.
// R3: Serial and channel headers read version 0x1 in bits 19 to 16.
// R4: Low identifier word is sticky, writable only while unlocked, reset zero.
// R5: High identifier word is sticky, writable only while unlocked, reset zero.
// R6: Channel header reads identifier 0x2 in bits 15 to 0.
// R7: Next pointers in bits 31 to 20 writable when unlocked, reset zero.
// R8: Extra channel count in bits 2 to 0 reads zero.
// R9: Low priority extra channel count in bits 6 to 4 reads zero.
// R10: Arbitration reference clock in bits 9 to 8 reads zero.
// R11: Table entry size reads 0x2 upstream, 0x0 downstream.
// R12: Fixed fields ignore writes; sticky fields survive all but fundamental reset.
module pcie_ext_cap_error_log_serial_vc #(
   parameter bit IS_UPSTREAM = 1'b1
) (
   // Clock and resets
   input wire logic i_clk,
   input wire logic i_srst,
   input wire logic i_hot_rst,
   // Register port
   input wire logic [ext_cap_pkg::ADDR_W-1:0] i_addr,
   input wire logic [ext_cap_pkg::DATA_W-1:0] i_wr_data,
   input wire logic i_wr_en,
   input wire logic i_rd_en,
   output logic [ext_cap_pkg::DATA_W-1:0] o_rd_data,
   output logic o_rd_valid,
   // Error logging
   input wire logic i_err_log_en,
   input wire logic [127:0] i_err_header,
   input wire logic i_err_rearm,
   output logic o_log_full,
   // Identifier to the rest of the port
   output logic [63:0] o_unique_id
);

   typedef struct packed {
      logic [31:0] rd_data;
      logic rd_valid;
      logic [31:0] uid_low;
      logic [31:0] uid_high;
      logic [11:0] serial_next_ptr;
      logic [11:0] vchan_next_ptr;
      logic unlock;
   } bank_state_t;

   localparam bank_state_t BANK_RESET = '{
      rd_data: 32'h0000_0000,
      rd_valid: 1'b0,
      uid_low: ext_cap_pkg::UID_RESET,
      uid_high: ext_cap_pkg::UID_RESET,
      serial_next_ptr: ext_cap_pkg::NEXT_PTR_RESET,
      vchan_next_ptr: ext_cap_pkg::NEXT_PTR_RESET,
      unlock: ext_cap_pkg::UNLOCK_RESET
   };

   // Entry size is fixed by the port's place in the switch
   localparam logic [1:0] ENTRY_SIZE = IS_UPSTREAM ?
      ext_cap_pkg::ENTRY_SIZE_4BIT : ext_cap_pkg::ENTRY_SIZE_1BIT; // [R11]

   bank_state_t state_reg;
   bank_state_t state_next;

   hdr_log_if log ();

   // Header store keeps the first error until the error logic rearms it
   error_header_store u_store (
      .i_clk(i_clk),
      .i_srst(i_srst),
      .log(log)
   );

   // Error side feeds the store directly; it shares our clock
   assign log.capture = i_err_log_en;
   assign log.rearm = i_err_rearm;
   assign log.header = i_err_header;

   // Word address match, used by the write and read paths
   function automatic logic hits(input logic [11:0] addr, input logic [11:0] off);
      hits = (addr == off);
   endfunction

   // Capability header word from its identifier and next pointer
   function automatic logic [31:0] cap_header(input logic [15:0] id, input logic [11:0] ptr);
      logic [31:0] w;
      w = 32'h0000_0000;
      w[ext_cap_pkg::CAP_ID_LSB +: 16] = id;
      w[ext_cap_pkg::CAP_VER_LSB +: 4] = ext_cap_pkg::CAP_VERSION; // [R3]
      w[ext_cap_pkg::NEXT_PTR_LSB +: 12] = ptr;
      return w;
   endfunction

   // Port VC capability one; reserved bits stay zero
   function automatic logic [31:0] port_vchan_cap1();
      logic [31:0] w;
      w = 32'h0000_0000;
      w[ext_cap_pkg::EXTRA_VC_LSB +: 3] = ext_cap_pkg::EXTRA_VC_COUNT; // [R8]
      w[ext_cap_pkg::LP_EXTRA_VC_LSB +: 3] = ext_cap_pkg::LP_EXTRA_VC_COUNT; // [R9]
      w[ext_cap_pkg::ARB_REF_CLK_LSB +: 2] = ext_cap_pkg::ARB_REF_CLK; // [R10]
      w[ext_cap_pkg::ENTRY_SIZE_LSB +: 2] = ENTRY_SIZE; // [R11]
      return w;
   endfunction

   // Read mux; unmapped addresses read as zero
   function automatic logic [31:0] read_word(input logic [11:0] addr, input bank_state_t s,
                                             input logic [3:0][31:0] hdr, input logic full);
      logic [31:0] w;
      w = 32'h0000_0000;
      if (hits(addr, ext_cap_pkg::OFF_ERR_HDR0)) w = hdr[0]; // [R1]
      if (hits(addr, ext_cap_pkg::OFF_ERR_HDR1)) w = hdr[1];
      if (hits(addr, ext_cap_pkg::OFF_ERR_HDR2)) w = hdr[2];
      if (hits(addr, ext_cap_pkg::OFF_ERR_HDR3)) w = hdr[3];
      if (hits(addr, ext_cap_pkg::OFF_SERIAL_CAP)) begin
         w = cap_header(ext_cap_pkg::CAP_ID_SERIAL, s.serial_next_ptr); // [R2]
      end
      if (hits(addr, ext_cap_pkg::OFF_UID_LOW)) w = s.uid_low;
      if (hits(addr, ext_cap_pkg::OFF_UID_HIGH)) w = s.uid_high;
      if (hits(addr, ext_cap_pkg::OFF_VCHAN_CAP)) begin
         w = cap_header(ext_cap_pkg::CAP_ID_VCHAN, s.vchan_next_ptr); // [R6]
      end
      if (hits(addr, ext_cap_pkg::OFF_PORT_VCHAN_CAP1)) w = port_vchan_cap1();
      if (hits(addr, ext_cap_pkg::OFF_LOCK_STATUS)) begin
         w[ext_cap_pkg::UNLOCK_BIT] = s.unlock;
         w[ext_cap_pkg::LOG_FULL_BIT] = full;
      end
      return w;
   endfunction

   // Next state: writes, hot reset, then the read answer
   always_comb begin
      state_next = state_reg;
      // Lock-writable fields move only while software has unlocked them
      if (i_wr_en && state_reg.unlock) begin
         if (hits(i_addr, ext_cap_pkg::OFF_UID_LOW)) begin
            state_next.uid_low = i_wr_data; // [R4]
         end
         if (hits(i_addr, ext_cap_pkg::OFF_UID_HIGH)) begin
            state_next.uid_high = i_wr_data; // [R5]
         end
         if (hits(i_addr, ext_cap_pkg::OFF_SERIAL_CAP)) begin
            state_next.serial_next_ptr = i_wr_data[ext_cap_pkg::NEXT_PTR_LSB +: 12]; // [R7]
         end
         if (hits(i_addr, ext_cap_pkg::OFF_VCHAN_CAP)) begin
            state_next.vchan_next_ptr = i_wr_data[ext_cap_pkg::NEXT_PTR_LSB +: 12]; // [R7]
         end
      end
      // The lock itself is always writable; the log-full bit is status only
      if (i_wr_en && hits(i_addr, ext_cap_pkg::OFF_LOCK_STATUS)) begin
         state_next.unlock = i_wr_data[ext_cap_pkg::UNLOCK_BIT];
      end
      // Hot reset clears non-sticky fields; identifier and log stay put
      if (i_hot_rst) begin
         state_next.serial_next_ptr = ext_cap_pkg::NEXT_PTR_RESET; // [R12]
         state_next.vchan_next_ptr = ext_cap_pkg::NEXT_PTR_RESET; // [R7]
         state_next.unlock = ext_cap_pkg::UNLOCK_RESET;
      end
      // Read data stand only in the cycle after the strobe, zero otherwise
      state_next.rd_valid = i_rd_en;
      state_next.rd_data = i_rd_en ? read_word(i_addr, state_reg, log.words, log.full) : 32'h0000_0000;
   end

   // Fundamental reset is the only one that clears sticky state
   always_ff @(posedge i_clk) begin
      if (i_srst) begin
         state_reg <= BANK_RESET;
      end else begin
         state_reg <= state_next;
      end
   end

   // Outputs straight from flip-flops
   assign o_rd_data = state_reg.rd_data;
   assign o_rd_valid = state_reg.rd_valid;
   assign o_unique_id = {state_reg.uid_high, state_reg.uid_low};
   assign o_log_full = log.full;

   // Checks run on the single clock; fundamental reset silences them
   default clocking cb @(posedge i_clk);
   endclocking
   default disable iff (i_srst);

   // An armed capture lands words 0 and 3 and marks the log full
   property p_hdr_capture;
      i_err_log_en && !log.full |=>
         log.full && (log.words[0] == $past(i_err_header[31:0]))
         && (log.words[3] == $past(i_err_header[127:96]));
   endproperty
   a_hdr_capture: assert property (p_hdr_capture) // [R1]
      else $error("header log did not capture the first error");

   // Once full, later errors without a rearm leave the log untouched
   property p_hdr_first_only;
      log.full && i_err_log_en && !i_err_rearm |=> $stable(log.words);
   endproperty
   a_hdr_first_only: assert property (p_hdr_first_only) // [R1]
      else $error("header log overwritten by a later error");

   // Serial header identifier
   property p_serial_id;
      i_rd_en && (i_addr == ext_cap_pkg::OFF_SERIAL_CAP) |=>
         o_rd_valid && (o_rd_data[15:0] == ext_cap_pkg::CAP_ID_SERIAL);
   endproperty
   a_serial_id: assert property (p_serial_id) // [R2]
      else $error("serial header identifier wrong");

   // Both headers carry the same version
   property p_cap_version;
      i_rd_en && ((i_addr == ext_cap_pkg::OFF_SERIAL_CAP) || (i_addr == ext_cap_pkg::OFF_VCHAN_CAP))
         |=> (o_rd_data[19:16] == ext_cap_pkg::CAP_VERSION);
   endproperty
   a_cap_version: assert property (p_cap_version) // [R3]
      else $error("capability version wrong");

   // Unlocked write to the low word shows up on the identifier output
   property p_uid_low_write;
      i_wr_en && state_reg.unlock && (i_addr == ext_cap_pkg::OFF_UID_LOW) && !i_hot_rst
         |=> (o_unique_id[31:0] == $past(i_wr_data));
   endproperty
   a_uid_low_write: assert property (p_uid_low_write) // [R4]
      else $error("low identifier word not written");

   // Locked write to the high word is ignored
   property p_uid_high_locked;
      i_wr_en && !state_reg.unlock && (i_addr == ext_cap_pkg::OFF_UID_HIGH)
         |=> $stable(o_unique_id[63:32]);
   endproperty
   a_uid_high_locked: assert property (p_uid_high_locked) // [R5]
      else $error("high identifier word changed while locked");

   // Channel header identifier
   property p_vchan_id;
      i_rd_en && (i_addr == ext_cap_pkg::OFF_VCHAN_CAP) |=>
         (o_rd_data[15:0] == ext_cap_pkg::CAP_ID_VCHAN);
   endproperty
   a_vchan_id: assert property (p_vchan_id) // [R6]
      else $error("channel header identifier wrong");

   // Hot reset returns the channel header's next pointer to zero, then a read shows it
   property p_next_ptr_hot;
      i_hot_rst ##1 i_rd_en && (i_addr == ext_cap_pkg::OFF_VCHAN_CAP) && !i_wr_en
         |=> (o_rd_data[31:20] == ext_cap_pkg::NEXT_PTR_RESET);
   endproperty
   a_next_ptr_hot: assert property (p_next_ptr_hot) // [R7]
      else $error("next pointer not cleared by hot reset");

   // Port VC capability one reads its fixed pattern
   property p_pvc_counts;
      i_rd_en && (i_addr == ext_cap_pkg::OFF_PORT_VCHAN_CAP1) |=>
         (o_rd_data[2:0] == ext_cap_pkg::EXTRA_VC_COUNT)
         && (o_rd_data[6:4] == ext_cap_pkg::LP_EXTRA_VC_COUNT);
   endproperty
   a_pvc_counts: assert property (p_pvc_counts) // [R8]
      else $error("extra channel counts not zero");

   property p_pvc_fixed;
      i_rd_en && (i_addr == ext_cap_pkg::OFF_PORT_VCHAN_CAP1) |=>
         (o_rd_data[9:8] == ext_cap_pkg::ARB_REF_CLK) && (o_rd_data[11:10] == ENTRY_SIZE)
         && (o_rd_data[31:12] == 20'h00000) && !o_rd_data[3] && !o_rd_data[7];
   endproperty
   a_pvc_fixed: assert property (p_pvc_fixed) // [R10]
      else $error("port channel capability fixed fields wrong");

   // Entry size follows the port's role
   property p_entry_size;
      i_rd_en && (i_addr == ext_cap_pkg::OFF_PORT_VCHAN_CAP1) |=>
         (o_rd_data[11:10] == (IS_UPSTREAM ? 2'h2 : 2'h0));
   endproperty
   a_entry_size: assert property (p_entry_size) // [R11]
      else $error("table entry size wrong for this port");

   // Identifier and log survive a hot reset with no write, error or rearm beside it
   property p_sticky_hot;
      i_hot_rst && !i_wr_en && !i_err_log_en && !i_err_rearm
         |=> $stable(o_unique_id) && $stable(log.words) && $stable(log.full);
   endproperty
   a_sticky_hot: assert property (p_sticky_hot) // [R12]
      else $error("sticky state lost on hot reset");

   // Read data stand one cycle only, unless another strobe follows at once
   property p_read_one_cycle;
      o_rd_valid && !i_rd_en |=> !o_rd_valid && (o_rd_data == 32'h0000_0000);
   endproperty
   a_read_one_cycle: assert property (p_read_one_cycle) // [R12]
      else $error("read data held past one cycle");

   // Low priority count checked alone, so a fault there names its own field
   property p_lp_extra_count;
      i_rd_en && (i_addr == ext_cap_pkg::OFF_PORT_VCHAN_CAP1) |=>
         (o_rd_data[6:4] == ext_cap_pkg::LP_EXTRA_VC_COUNT);
   endproperty
   a_lp_extra_count: assert property (p_lp_extra_count) // [R9]
      else $error("low priority extra channel count not zero");

   // A rearm with no error beside it empties the log
   property p_rearm_empty;
      i_err_rearm && !i_err_log_en |=> !log.full;
   endproperty
   a_rearm_empty: assert property (p_rearm_empty) // [R1]
      else $error("header log not emptied by rearm");

   // Rearm beside an error: the set wins, so the new header lands and the log stays full
   property p_rearm_capture;
      i_err_log_en && i_err_rearm |=>
         log.full && (log.words[1] == $past(i_err_header[63:32]))
         && (log.words[2] == $past(i_err_header[95:64]));
   endproperty
   a_rearm_capture: assert property (p_rearm_capture) // [R1]
      else $error("header not taken on rearm with capture");

   // Unlocked write to the channel header moves its next pointer
   property p_vchan_ptr_write;
      i_wr_en && state_reg.unlock && (i_addr == ext_cap_pkg::OFF_VCHAN_CAP) && !i_hot_rst
         |=> (state_reg.vchan_next_ptr == $past(i_wr_data[31:20]));
   endproperty
   a_vchan_ptr_write: assert property (p_vchan_ptr_write) // [R7]
      else $error("channel next pointer not written");

   // Locked write to the serial header leaves its next pointer alone
   property p_serial_ptr_locked;
      i_wr_en && !state_reg.unlock && (i_addr == ext_cap_pkg::OFF_SERIAL_CAP) && !i_hot_rst
         |=> $stable(state_reg.serial_next_ptr);
   endproperty
   a_serial_ptr_locked: assert property (p_serial_ptr_locked) // [R7]
      else $error("serial next pointer changed while locked");

   // Hot reset always relocks, even against an unlock write in the same cycle
   property p_hot_relock;
      i_hot_rst |=> !state_reg.unlock;
   endproperty
   a_hot_relock: assert property (p_hot_relock) // [R12]
      else $error("hot reset left the bank unlocked");

   // Main scenarios
   c_capture: cover property (i_err_log_en && !log.full ##1 log.full);
   c_unlock_write: cover property (state_reg.unlock && i_wr_en && (i_addr == ext_cap_pkg::OFF_UID_HIGH));
   c_hot_reset: cover property (i_hot_rst ##1 i_rd_en);
   c_rearm_same: cover property (log.full && i_err_log_en && i_err_rearm);

endmodule

`default_nettype wire

// *** tb/testbench.sv ***
// Self-checking bench for the extended capability register bank.
// Assumes the package is compiled first; drives every port itself.
`timescale 1ns/1ns
`default_nettype none

module testbench;
   logic i_clk;
   logic i_srst;
   logic i_hot_rst;
   logic [11:0] i_addr;
   logic [31:0] i_wr_data;
   logic i_wr_en;
   logic i_rd_en;
   logic [31:0] o_rd_data;
   logic [31:0] dn_rd_data;
   logic o_rd_valid;
   logic i_err_log_en;
   logic [127:0] i_err_header;
   logic i_err_rearm;
   logic o_log_full;
   logic [63:0] o_unique_id;
   int bad_count;
   int compares;
   int cycles;
   bit rd_now; // Caller sits just after a rising edge
   logic [127:0] hdr_a;
   logic [127:0] hdr_b;

   // Upstream port under test
   pcie_ext_cap_error_log_serial_vc #(.IS_UPSTREAM(1'b1)) i_pcie_ext_cap_error_log_serial_vc (
      .i_clk(i_clk), .i_srst(i_srst), .i_hot_rst(i_hot_rst), .i_addr(i_addr),
      .i_wr_data(i_wr_data), .i_wr_en(i_wr_en), .i_rd_en(i_rd_en), .o_rd_data(o_rd_data),
      .o_rd_valid(o_rd_valid), .i_err_log_en(i_err_log_en), .i_err_header(i_err_header),
      .i_err_rearm(i_err_rearm), .o_log_full(o_log_full), .o_unique_id(o_unique_id));

   // Downstream copy shares every input; only its read data is watched
   pcie_ext_cap_error_log_serial_vc #(.IS_UPSTREAM(1'b0)) i_pcie_ext_cap_error_log_serial_vc_dn (
      .i_clk(i_clk), .i_srst(i_srst), .i_hot_rst(i_hot_rst), .i_addr(i_addr),
      .i_wr_data(i_wr_data), .i_wr_en(i_wr_en), .i_rd_en(i_rd_en), .o_rd_data(dn_rd_data),
      .o_rd_valid(), .i_err_log_en(i_err_log_en), .i_err_header(i_err_header),
      .i_err_rearm(i_err_rearm), .o_log_full(), .o_unique_id());

   // Clock at 100 ns period
   initial begin
      i_clk = 1'b0;
      forever #50 i_clk = ~i_clk;
   end

   // Verdict and end of run, reached from the main sequence or the timeout
   task automatic results();
      if (bad_count == 0 && compares > 0) begin
         $display("STATUS OK");
      end else begin
         $display("STATUS NOT OK");
      end
      $finish;
   endtask

   // Single compare for every kind of value
   task automatic chk(input string name, input logic [63:0] exp, input logic [63:0] got);
      compares++;
      if (got !== exp) begin
         bad_count++;
         $display("MISMATCH %s expected %h seen %h", name, exp, got);
      end
   endtask

   // One-cycle write strobe
   task automatic wr(input logic [11:0] a, input logic [31:0] d);
      @(posedge i_clk);
      i_addr <= a;
      i_wr_data <= d;
      i_wr_en <= 1'b1;
      @(posedge i_clk);
      i_wr_en <= 1'b0;
   endtask

   // One-cycle read; data is looked at in the single cycle it stands, then must drop
   // With rd_now set the strobe goes out at once, right behind a reset pulse
   task automatic rd(input logic [11:0] a, input logic [31:0] exp);
      logic [31:0] exp_dn;
      exp_dn = (a == ext_cap_pkg::OFF_PORT_VCHAN_CAP1) ? (exp & 32'hffff_f3ff) : exp;
      if (!rd_now) @(posedge i_clk);
      rd_now = 1'b0;
      i_addr <= a;
      i_rd_en <= 1'b1;
      @(posedge i_clk);
      i_rd_en <= 1'b0;
      @(negedge i_clk);
      chk("rd_valid", 64'h1, {63'h0, o_rd_valid});
      chk("rd_data", {32'h0, exp}, {32'h0, o_rd_data});
      chk("dn_rd_data", {32'h0, exp_dn}, {32'h0, dn_rd_data});
      @(negedge i_clk);
      chk("rd_valid_after", 64'h0, {63'h0, o_rd_valid});
      chk("rd_data_after", 64'h0, {32'h0, o_rd_data});
   endtask

   // Error-side pulse: capture and/or rearm in one cycle
   task automatic log_pulse(input logic [127:0] h, input logic en, input logic re);
      @(posedge i_clk);
      i_err_header <= h;
      i_err_log_en <= en;
      i_err_rearm <= re;
      @(posedge i_clk);
      i_err_log_en <= 1'b0;
      i_err_rearm <= 1'b0;
      @(negedge i_clk);
   endtask

   // Four header words read back in order, word i from bits 32*i+31:32*i
   task automatic rd_log(input logic [127:0] h);
      for (int i = 0; i < 4; i++) begin
         rd(ext_cap_pkg::OFF_ERR_HDR0 + 12'(4 * i), h[32*i+:32]);
      end
   endtask

   // One-cycle reset pulse on either reset input
   task automatic pulse_rst(input logic fund);
      @(posedge i_clk);
      if (fund) i_srst <= 1'b1;
      else i_hot_rst <= 1'b1;
      @(posedge i_clk);
      i_srst <= 1'b0;
      i_hot_rst <= 1'b0;
   endtask

   // Hang guard; the whole sequence needs well under a thousand cycles
   always @(posedge i_clk) begin
      cycles <= cycles + 1;
      if (cycles == 3000) begin
         bad_count++;
         results();
      end
   end

   // Main sequence
   initial begin
      bad_count = 0;
      compares = 0;
      cycles = 0;
      i_srst = 1'b1;
      i_hot_rst = 1'b0;
      i_addr = 12'h000;
      i_wr_data = 32'h0000_0000;
      i_wr_en = 1'b0;
      i_rd_en = 1'b0;
      i_err_log_en = 1'b0;
      i_err_header = 128'h0;
      i_err_rearm = 1'b0;
      hdr_a = 128'h4444_4444_3333_3333_2222_2222_1111_1111;
      hdr_b = 128'hdead_0004_beef_0003_cafe_0002_f00d_0001;
      repeat (4) @(posedge i_clk);
      i_srst <= 1'b0;
      // Reset values and fixed fields of every register but the lock and status word, unmapped place too
      rd_log(128'h0);
      rd(ext_cap_pkg::OFF_SERIAL_CAP, 32'h0001_0003);
      rd(ext_cap_pkg::OFF_UID_LOW, 32'h0000_0000);
      rd(ext_cap_pkg::OFF_UID_HIGH, 32'h0000_0000);
      rd(ext_cap_pkg::OFF_VCHAN_CAP, 32'h0001_0002);
      rd(ext_cap_pkg::OFF_PORT_VCHAN_CAP1, 32'h0000_0800);
      rd(12'h3fc, 32'h0000_0000);
      chk("log_full", 64'h0, {63'h0, o_log_full});
      // Locked: identifier and pointer writes are refused
      wr(ext_cap_pkg::OFF_UID_LOW, 32'h1234_5678);
      wr(ext_cap_pkg::OFF_UID_HIGH, 32'h9abc_def0);
      wr(ext_cap_pkg::OFF_SERIAL_CAP, 32'hffff_ffff);
      rd(ext_cap_pkg::OFF_UID_LOW, 32'h0000_0000);
      rd(ext_cap_pkg::OFF_UID_HIGH, 32'h0000_0000);
      rd(ext_cap_pkg::OFF_SERIAL_CAP, 32'h0001_0003);
      // Unlocked: writable fields take data, fixed fields keep their values
      wr(ext_cap_pkg::OFF_LOCK_STATUS, 32'h0000_0001);
      rd(ext_cap_pkg::OFF_LOCK_STATUS, 32'h0000_0001);
      wr(ext_cap_pkg::OFF_UID_LOW, 32'h1234_5678);
      wr(ext_cap_pkg::OFF_UID_HIGH, 32'h9abc_def0);
      wr(ext_cap_pkg::OFF_SERIAL_CAP, 32'hffff_ffff);
      wr(ext_cap_pkg::OFF_VCHAN_CAP, 32'habcf_ffff);
      wr(ext_cap_pkg::OFF_PORT_VCHAN_CAP1, 32'hffff_ffff);
      wr(ext_cap_pkg::OFF_ERR_HDR0, 32'hffff_ffff);
      rd(ext_cap_pkg::OFF_UID_LOW, 32'h1234_5678);
      rd(ext_cap_pkg::OFF_UID_HIGH, 32'h9abc_def0);
      chk("unique_id", 64'h9abc_def0_1234_5678, o_unique_id);
      rd(ext_cap_pkg::OFF_SERIAL_CAP, 32'hfff1_0003);
      rd(ext_cap_pkg::OFF_VCHAN_CAP, 32'habc1_0002);
      rd(ext_cap_pkg::OFF_PORT_VCHAN_CAP1, 32'h0000_0800);
      rd(ext_cap_pkg::OFF_ERR_HDR0, 32'h0000_0000);
      // Hot reset: pointers and unlock clear, identifier is sticky; first read follows at once
      pulse_rst(1'b0);
      rd_now = 1'b1;
      rd(ext_cap_pkg::OFF_VCHAN_CAP, 32'h0001_0002);
      rd(ext_cap_pkg::OFF_SERIAL_CAP, 32'h0001_0003);
      rd(ext_cap_pkg::OFF_LOCK_STATUS, 32'h0000_0000);
      rd(ext_cap_pkg::OFF_UID_LOW, 32'h1234_5678);
      wr(ext_cap_pkg::OFF_UID_HIGH, 32'h0000_0001);
      rd(ext_cap_pkg::OFF_UID_HIGH, 32'h9abc_def0);
      // First error is logged; a later one while full is dropped
      log_pulse(hdr_a, 1'b1, 1'b0);
      chk("log_full", 64'h1, {63'h0, o_log_full});
      log_pulse(hdr_b, 1'b1, 1'b0);
      rd_log(hdr_a);
      rd(ext_cap_pkg::OFF_LOCK_STATUS, 32'h0000_0002);
      pulse_rst(1'b0);
      rd_log(hdr_a);
      // Rearm empties the log; the next error is taken
      log_pulse(128'h0, 1'b0, 1'b1);
      chk("log_full", 64'h0, {63'h0, o_log_full});
      log_pulse(hdr_b, 1'b1, 1'b0);
      rd_log(hdr_b);
      // Rearm together with capture takes the new header and stays full
      log_pulse(hdr_a, 1'b1, 1'b1);
      chk("log_full", 64'h1, {63'h0, o_log_full});
      rd_log(hdr_a);
      // Fundamental reset clears even the sticky contents
      pulse_rst(1'b1);
      @(negedge i_clk);
      chk("log_full", 64'h0, {63'h0, o_log_full});
      chk("unique_id", 64'h0, o_unique_id);
      rd_log(128'h0);
      rd(ext_cap_pkg::OFF_UID_LOW, 32'h0000_0000);
      results();
   end
endmodule

`default_nettype wire
